// >>> clock_ratio_strap_decoder.sv
// power-on strap capture and clock ratio decode with apb status access
`timescale 1ns/10ps
`default_nettype none

module clock_ratio_strap_decoder
	import clk_strap_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        CE,
	input  wire logic [3:0]  PLATFORM_RATIO_STRAP,
	input  wire logic        CORE_RATIO_STRAP_BUS_CTL,
	input  wire logic        CORE_RATIO_STRAP_ADDR_LATCH,
	input  wire logic        CORE_RATIO_STRAP_GP2,
	input  wire logic        PCI_ARB_STRAP,
	input  wire logic [3:0]  CFG_SPARE_STRAP,
	input  wire logic [15:0] REF_CLK_MHZ,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output var  logic [31:0] PRDATA,
	output var  logic        PREADY,
	output var  logic        PSLVERR,
	output var  logic [4:0]  PLATFORM_MULT,
	output var  logic [3:0]  CORE_HALF_RATIO,
	output var  logic        PLATFORM_CFG_INVALID,
	output var  logic        CORE_CFG_INVALID,
	output var  logic        PCI_ADDR_DRIVE_EN,
	output var  logic        PCI_CLK_REQUIRED
);

	// ************************************************************
	// strap synchronisers
	// ************************************************************
	logic [11:0] strap_raw;
	logic [11:0] strap_sync_q;

	assign strap_raw = {CFG_SPARE_STRAP, PCI_ARB_STRAP,
		CORE_RATIO_STRAP_BUS_CTL, CORE_RATIO_STRAP_ADDR_LATCH,
		CORE_RATIO_STRAP_GP2, PLATFORM_RATIO_STRAP};

	strap_sync #(.WIDTH(12)) u_strap_sync (
		.clk (CLK),
		.ce  (CE),
		.d   (strap_raw),
		.q   (strap_sync_q)
	);

	// ref clock figure is quasi-static board data, synchronised too
	logic [15:0] ref_mhz_q;

	strap_sync #(.WIDTH(16)) u_ref_sync (
		.clk (CLK),
		.ce  (CE),
		.d   (REF_CLK_MHZ),
		.q   (ref_mhz_q)
	);

	// ************************************************************
	// decode tables
	// ************************************************************
	function automatic mult_t plat_decode(input logic [3:0] code);
		case (code)
			4'h0:    plat_decode = 5'd16;
			4'h3:    plat_decode = 5'd3;
			4'h4:    plat_decode = 5'd4;
			4'h5:    plat_decode = 5'd5;
			4'h6:    plat_decode = 5'd6;
			4'h8:    plat_decode = 5'd8;
			4'h9:    plat_decode = 5'd9;
			4'hA:    plat_decode = 5'd10;
			4'hC:    plat_decode = 5'd12;
			default: plat_decode = 5'd0;
		endcase
	endfunction

	// order: bus control, address latch, gp2 (msb first)
	function automatic half_ratio_t core_decode(input logic [2:0] code);
		case (code)
			3'h0:    core_decode = CORE_4_1;
			3'h3:    core_decode = CORE_3_2;
			3'h4:    core_decode = CORE_2_1;
			3'h5:    core_decode = CORE_5_2;
			3'h6:    core_decode = CORE_3_1;
			3'h7:    core_decode = CORE_7_2;
			default: core_decode = 4'd0;
		endcase
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [3:0]  plat_code;
		logic [2:0]  core_code;
		logic        arb_internal;
		logic [3:0]  spare;
		mult_t       plat_mult;
		half_ratio_t core_half;
		logic        plat_bad;
		logic        core_bad;
		logic        pci_need;
		logic        plat_low;
		logic        mem_bad;
		logic [15:0] plat_mhz;
		logic [31:0] disable_bits;
		logic        pci_drive;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic        access;
	logic [20:0] plat_prod;
	logic [15:0] mem_mhz;

	assign access = PSEL && PENABLE && !st_reg.pready;

	always_comb begin
		st_next = st_reg;
		// widen before multiplying so the product keeps its top bits
		plat_prod = 21'(ref_mhz_q) * 21'(st_reg.plat_mult);
		// memory clock runs at half the platform rate
		mem_mhz = st_reg.plat_mhz >> 1;
		if (SYS_RST) begin
			// straps tracked throughout reset, frozen at release
			st_next.plat_code    = strap_sync_q[3:0];
			st_next.core_code    = strap_sync_q[6:4];
			st_next.arb_internal = strap_sync_q[7];
			st_next.spare        = strap_sync_q[11:8];
			st_next.plat_mult    = plat_decode(strap_sync_q[3:0]);
			st_next.core_half    = core_decode(strap_sync_q[6:4]);
			st_next.disable_bits = DISABLE_RESET;
			st_next.prdata       = 32'h0000_0000;
			st_next.pready       = 1'b0;
			st_next.pslverr      = 1'b0;
			st_next.pci_drive    = 1'b0;
		end else begin
			// straps and ratios held until next reset
			st_next.plat_bad = (st_reg.plat_mult == 5'd0);
			st_next.core_bad = (st_reg.core_half == 4'd0);
			// platform clock is the memory data rate and bus clock
			st_next.plat_mhz = (plat_prod > 21'h00FFFF) ? 16'hFFFF
				: plat_prod[15:0];
			st_next.plat_low = (st_reg.plat_mhz < PLAT_MIN_MHZ);
			st_next.mem_bad = (mem_mhz < MEM_MIN_MHZ)
				|| (mem_mhz > MEM_MAX_MHZ);
			st_next.pci_need = (ref_mhz_q < PCI_REF_MIN_MHZ)
				|| (ref_mhz_q > PCI_REF_MAX_MHZ);
			// arbiter strap wins over the pci disable bit
			st_next.pci_drive = st_reg.arb_internal;
			st_next.pready = access;
			st_next.pslverr = 1'b0;
			if (access) begin
				st_next.prdata = 32'h0000_0000;
				case (PADDR)
					STATUS_OFFSET: begin
						st_next.prdata[ST_PLAT_BAD_BIT] = st_reg.plat_bad;
						st_next.prdata[ST_CORE_BAD_BIT] = st_reg.core_bad;
						st_next.prdata[ST_ARB_BIT] = st_reg.arb_internal;
						st_next.prdata[ST_PCI_NEED_BIT] = st_reg.pci_need;
						st_next.prdata[ST_PLAT_LOW_BIT] = st_reg.plat_low;
						st_next.prdata[ST_MEM_BAD_BIT] = st_reg.mem_bad;
					end
					RATIO_OFFSET: begin
						st_next.prdata = {12'h000, st_reg.core_half,
							st_reg.core_code, 1'b0, st_reg.plat_mult,
							3'h0, st_reg.plat_code};
					end
					FREQ_OFFSET: begin
						st_next.prdata = {mem_mhz, st_reg.plat_mhz};
					end
					DISABLE_OFFSET: begin
						if (PWRITE) begin
							st_next.disable_bits = PWDATA;
						end
						st_next.prdata = st_reg.disable_bits;
					end
					SPARE_OFFSET: begin
						st_next.prdata = {28'h0000000, st_reg.spare};
					end
					default: begin
						st_next.pslverr = 1'b1;
					end
				endcase
				if (PWRITE) begin
					st_next.prdata = 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (CE) begin
			st_reg <= st_next;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign PRDATA               = st_reg.prdata;
	assign PREADY               = st_reg.pready;
	assign PSLVERR              = st_reg.pslverr;
	assign PLATFORM_MULT        = st_reg.plat_mult;
	assign CORE_HALF_RATIO      = st_reg.core_half;
	assign PLATFORM_CFG_INVALID = st_reg.plat_bad;
	assign CORE_CFG_INVALID     = st_reg.core_bad;
	assign PCI_ADDR_DRIVE_EN    = st_reg.pci_drive;
	assign PCI_CLK_REQUIRED     = st_reg.pci_need;

endmodule

`default_nettype wire

// >>> clk_strap_pkg.sv
// constants and types for the clock ratio strap decoder
//
// ************************************************************
// Overview of operation
// ************************************************************
// Overview of operation
// - capture four-bit platform ratio during reset
// - decode platform code to reference multiplier
// - capture and decode three-bit core ratio
// - platform clock equals memory data rate
// - memory clock is half platform clock
// - platform and core bus share one clock
// - pci clock optional for 33 to 66 MHz
// - arbiter strap drives pci address despite disable
package clk_strap_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [11:0] STATUS_OFFSET  = 12'h000;
	localparam logic [11:0] RATIO_OFFSET   = 12'h004;
	localparam logic [11:0] FREQ_OFFSET    = 12'h008;
	localparam logic [11:0] DISABLE_OFFSET = 12'h00C;
	localparam logic [11:0] SPARE_OFFSET   = 12'h010;

	// status register fields
	localparam int ST_PLAT_BAD_BIT = 0;
	localparam int ST_CORE_BAD_BIT = 1;
	localparam int ST_ARB_BIT      = 2;
	localparam int ST_PCI_NEED_BIT = 3;
	localparam int ST_PLAT_LOW_BIT = 4;
	localparam int ST_MEM_BAD_BIT  = 5;

	// device disable register field
	localparam int DIS_PCI_BIT = 0;
	localparam logic [31:0] DISABLE_RESET = 32'h0000_0000;

	// ************************************************************
	// frequency limits in MHz
	// ************************************************************
	localparam logic [15:0] PLAT_MIN_MHZ    = 16'd333;
	localparam logic [15:0] MEM_MIN_MHZ     = 16'd166;
	localparam logic [15:0] MEM_MAX_MHZ     = 16'd266;
	localparam logic [15:0] PCI_REF_MIN_MHZ = 16'd33;
	localparam logic [15:0] PCI_REF_MAX_MHZ = 16'd66;

	// core ratio in halves of the platform clock
	typedef logic [3:0] half_ratio_t;
	typedef logic [4:0] mult_t;

	localparam half_ratio_t CORE_4_1 = 4'd8;
	localparam half_ratio_t CORE_3_2 = 4'd3;
	localparam half_ratio_t CORE_2_1 = 4'd4;
	localparam half_ratio_t CORE_5_2 = 4'd5;
	localparam half_ratio_t CORE_3_1 = 4'd6;
	localparam half_ratio_t CORE_7_2 = 4'd7;

endpackage

// >>> strap_sync.sv
// two-stage synchroniser for a group of strap pins
`timescale 1ns/10ps
`default_nettype none

module strap_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (ce) begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// >>> strap_board_model.sv
// board straps: held in reset, bus traffic after
`timescale 1ns/10ps
`default_nettype none
module strap_board_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [6:0] code,
	output var  logic [6:0] pins
);
	logic [6:0] bus_reg = 7'h55;
	always @(posedge clk) bus_reg <= ~bus_reg;
	always_comb pins = rst ? code : bus_reg;
endmodule
`default_nettype wire

// >>> clock_ratio_strap_decoder_sva.sv
// port assertions for the strap decoder
`timescale 1ns/10ps
`default_nettype none
module clock_ratio_strap_decoder_sva (
	input wire logic       CLK,
	input wire logic       SYS_RST,
	input wire logic       PSEL,
	input wire logic       PENABLE,
	input wire logic       PREADY,
	input wire logic [4:0] PLATFORM_MULT,
	input wire logic [3:0] CORE_HALF_RATIO,
	input wire logic       PLATFORM_CFG_INVALID,
	input wire logic       CORE_CFG_INVALID,
	input wire logic       PCI_ADDR_DRIVE_EN
);
	logic [2:0] up_reg;
	logic       ok;
	always_ff @(posedge CLK)
		up_reg <= SYS_RST ? 3'h0 : up_reg + 3'(up_reg != 3'h7);
	assign ok = up_reg > 3'h3;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	AST_MULT_HOLD: assert property (ok |-> $stable(PLATFORM_MULT))
		else $error("mult moved");
	AST_HALF_HOLD: assert property (ok |-> $stable(CORE_HALF_RATIO))
		else $error("core ratio moved");
	AST_MULT_SET: assert property (ok |-> PLATFORM_MULT inside
		{0, 3, 4, 5, 6, 8, 9, 10, 12, 16}) else $error("bad mult");
	AST_HALF_SET: assert property (ok |-> CORE_HALF_RATIO inside
		{0, 3, 4, 5, 6, 7, 8}) else $error("bad core ratio");
	AST_PLAT_FLAG: assert property (ok |->
		PLATFORM_CFG_INVALID == (PLATFORM_MULT == 5'h0))
		else $error("platform flag");
	AST_CORE_FLAG: assert property (ok |->
		CORE_CFG_INVALID == (CORE_HALF_RATIO == 4'h0))
		else $error("core flag");
	AST_DRIVE_KEEP: assert property (ok |-> $stable(PCI_ADDR_DRIVE_EN))
		else $error("drive moved");
	AST_ONE_WAIT: assert property (PSEL && PENABLE && !PREADY
		|=> PREADY ##1 !PREADY) else $error("ready timing");
endmodule
bind clock_ratio_strap_decoder clock_ratio_strap_decoder_sva i_sva (
	.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PREADY(PREADY), .PLATFORM_MULT(PLATFORM_MULT),
	.CORE_HALF_RATIO(CORE_HALF_RATIO),
	.PLATFORM_CFG_INVALID(PLATFORM_CFG_INVALID),
	.CORE_CFG_INVALID(CORE_CFG_INVALID),
	.PCI_ADDR_DRIVE_EN(PCI_ADDR_DRIVE_EN));
`default_nettype wire

// >>> clock_ratio_strap_decoder_bench.sv
// self-checking bench for the strap decoder
`timescale 1ns/10ps
`default_nettype none
module clock_ratio_strap_decoder_bench;
	import clk_strap_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
	logic        pwr = 1'b0, arb = 1'b0, rdy, err, er, pb, cb, drv, pci;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic [15:0] rf = 16'h0;
	logic [6:0]  code = 7'h00, pins;
	logic [4:0]  mult;
	logic [3:0]  half;
	int          errors = 0, cmp_count = 0;
	logic [4:0]  mt [16] = '{16, 0, 0, 3, 4, 5, 6, 0, 8, 9, 10, 0, 12,
		0, 0, 0};
	logic [3:0]  ct [8] = '{8, 0, 0, 3, 4, 5, 6, 7};
	always #5 clk = ~clk;
	strap_board_model i_strap_board_model (.clk(clk), .rst(rst),
		.code(code), .pins(pins));
	// spare straps pulled low
	clock_ratio_strap_decoder i_clock_ratio_strap_decoder (
		.CLK(clk), .SYS_RST(rst), .CE(1'b1),
		.PLATFORM_RATIO_STRAP(pins[6:3]),
		.CORE_RATIO_STRAP_BUS_CTL(pins[2]),
		.CORE_RATIO_STRAP_ADDR_LATCH(pins[1]),
		.CORE_RATIO_STRAP_GP2(pins[0]), .PCI_ARB_STRAP(arb),
		.CFG_SPARE_STRAP(4'h0), .REF_CLK_MHZ(rf), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
		.PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
		.PLATFORM_MULT(mult), .CORE_HALF_RATIO(half),
		.PLATFORM_CFG_INVALID(pb), .CORE_CFG_INVALID(cb),
		.PCI_ADDR_DRIVE_EN(drv), .PCI_CLK_REQUIRED(pci));
	task automatic print_verdict();
		if (errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			print_verdict();
		end
		rd = prd;
		er = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic strap_sweep();
		logic [15:0] r, pm;
		logic [31:0] st;
		for (int i = 0; i < 16; i++) begin
			r = 16'd20 + 16'(i * 7);
			pm = r * mt[i];
			st = {26'h0, pm[15:1] < 166 || pm[15:1] > 266, pm < 333,
				r < 33 || r > 66, i[0], ct[i[2:0]] == 0, mt[i] == 0};
			code <= {i[3:0], i[2:0]};
			arb <= i[0];
			rf <= r;
			rst <= 1'b1;
			repeat (16) @(posedge clk);
			rst <= 1'b0;
			repeat (8) @(posedge clk);
			check("mult", mt[i], mult);
			check("half", ct[i[2:0]], half);
			check("flags", st[1:0], {cb, pb});
			check("pci clk", st[3], pci);
			apb(1'b0, RATIO_OFFSET, 32'h0);
			check("ratio", {12'h0, ct[i[2:0]], i[2:0], 1'b0, mt[i],
				3'h0, i[3:0]}, rd);
			apb(1'b0, FREQ_OFFSET, 32'h0);
			check("freq", {1'b0, pm[15:1], pm}, rd);
			apb(1'b0, STATUS_OFFSET, 32'h0);
			check("status", st, rd);
			apb(1'b1, DISABLE_OFFSET, 32'h1);
			check("drive", i[0], drv);
		end
	endtask
	task automatic reg_access();
		apb(1'b0, 12'h014, 32'h0);
		check("unmapped", 32'h1, er);
		apb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF);
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check("ro status", 32'h3D, rd);
		apb(1'b0, SPARE_OFFSET, 32'h0);
		check("spare", 32'h0, rd);
		check("spare err", 32'h0, er);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		strap_sweep();
		reg_access();
		print_verdict();
	end
endmodule
`default_nettype wire
